// file: rtl/uif_ctrl.sv
// Purpose: interrupt, fifo control and line format registers of a channel
// Assumes: bus strobes and engine events are one-cycle pulses on ref_clk
// Notes: fifo storage, shifters and baud generator live outside
//
// Contract
// - line status read clears line status interrupt
// - receive interrupt holds while count reaches trigger
// - receive holding read clears time-out interrupt
// - status read or transmit write clears transmit
// - modem status read clears modem and flow
// - xoff and special cleared by status read
// - status bits encode seven sources by priority
// - bit zero low while anything pending
// - bits five and four need enhanced enable
// - bits seven and six mirror fifo enable
// - fifo fields ignored unless enable bit written
// - receive fifo reset pulse, shifter untouched
// - transmit fifo reset pulse, shifter untouched
// - dma bit selects ready pin behaviour
// - transmit interrupt below trigger or on empty
// - one table select serves both directions
// - receive interrupt at selected receive trigger
// - fixed tables give the listed trigger levels
// - table three uses programmed levels by direction
// - word length codes give five to eight bits
// - stop select gives one, one-half, two
// - parity enable adds and checks parity bit
// - time-out after four chars plus twelve bits
// - only highest pending source is reported
`timescale 1ns/10ps
module uif_ctrl import uif_pkg::*; #(
    parameter int FIFO_DEPTH = 64
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cs,
    input wire logic [2:0] addr,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic [7:0] rhr_data,
    input wire logic [7:0] line_status,
    input wire logic [7:0] modem_status,
    input wire logic [UIF_CW-1:0] rx_count,
    input wire logic [UIF_CW-1:0] tx_count,
    input wire logic bit_tick,
    input wire logic rx_push_evt,
    input wire logic line_err_evt,
    input wire logic modem_evt,
    input wire logic xoff_evt,
    input wire logic xon_evt,
    input wire logic special_evt,
    input wire logic rts_rise_evt,
    input wire logic cts_rise_evt,
    output logic rx_pop,
    output logic tx_push,
    output logic [7:0] tx_data,
    output logic rx_fifo_reset,
    output logic tx_fifo_reset,
    output logic fifo_en,
    output logic dma_mode,
    output logic [3:0] data_bits,
    output logic stop_long,
    output logic stop_half,
    output logic parity_en,
    output logic irq,
    output logic receive_ready_pin_n,
    output logic transmit_ready_pin_n
);
    // ======================================================================
    // registers
    logic [7:0] ier, line_control, enhanced_feature_control, feature_control;
    logic [1:0] rx_idx, tx_idx;
    logic [UIF_CW-1:0] prog_rx, prog_tx, rx_trig, tx_trig;
    logic lsr_f, to_f, tx_f, ms_f, xoff_f, spc_f, rts_f, cts_f;
    logic tx_above, tx_low_q;
    logic [UIF_CW-1:0] to_cnt;

    // ======================================================================
    // address decode
    function automatic logic hit(input logic [2:0] a,
            input logic [2:0] off, input logic en);
        hit = en && (a == off);
    endfunction

    wire enh_set = (line_control == UIF_LCR_KEY);
    wire div_sel = line_control[UIF_LCR_DIV];
    wire enh_on = enhanced_feature_control[UIF_EFR_ENH];
    wire wr_ok = cs & wr_strobe;
    wire rd_ok = cs & rd_strobe;
    wire wr_thr = hit(addr, UIF_A_DATA, wr_ok & ~div_sel);
    wire wr_ier = hit(addr, UIF_A_IER, wr_ok & ~div_sel);
    wire wr_fcr = hit(addr, UIF_A_ISR, wr_ok & ~enh_set);
    wire wr_lcr = hit(addr, UIF_A_LCR, wr_ok);
    wire wr_efr = hit(addr, UIF_A_EFR, wr_ok & enh_set);
    wire wr_feature_control = hit(addr, UIF_A_FEATURE_CONTROL, wr_ok & enh_set);
    wire wr_trg = hit(addr, UIF_A_TRG, wr_ok & enh_set);
    wire rd_rhr = hit(addr, UIF_A_DATA, rd_ok & ~div_sel);
    wire rd_isr = hit(addr, UIF_A_ISR, rd_ok & ~enh_set);
    wire rd_lsr = hit(addr, UIF_A_LSR, rd_ok);
    wire rd_msr = hit(addr, UIF_A_MSR, rd_ok);
    wire fcr_go = wdata[UIF_FCR_EN];

    // ======================================================================
    // trigger levels and priority encoder
    uif_trig_sel u_trig (
        .fifo_en(fifo_en),
        .table_sel(feature_control[5:4]),
        .rx_idx(rx_idx),
        .tx_idx(tx_idx),
        .prog_rx(prog_rx),
        .prog_tx(prog_tx),
        .rx_trig(rx_trig),
        .tx_trig(tx_trig)
    );

    logic [UIF_NSRC-1:0] pend;
    logic [5:0] code;
    logic any;
    uif_int_prio u_prio (
        .pend(pend),
        .code(code),
        .any(any)
    );

    // each source gated by its enable before priority; time-out uses the receive enable
    wire rx_lvl = rx_count >= rx_trig;
    assign pend[0] = lsr_f & ier[UIF_IE_LS];
    assign pend[1] = to_f & ier[UIF_IE_RX];
    assign pend[2] = rx_lvl & ier[UIF_IE_RX];
    assign pend[3] = tx_f & ier[UIF_IE_TX];
    assign pend[4] = ms_f & ier[UIF_IE_MS];
    assign pend[5] = enh_on & ier[UIF_IE_XOFF] & (xoff_f | spc_f);
    assign pend[6] = enh_on & ((rts_f & ier[UIF_IE_RTS])
        | (cts_f & ier[UIF_IE_CTS]));
    wire [7:0] isr_val = {{2{fifo_en}}, code};
    wire tx_shown = rd_isr & (code == UIF_ISR_CODE[3]);
    assign irq = any;

    // ======================================================================
    // transmit ready condition: below trigger, or empty after short reload
    wire tx_empty = (tx_count == '0);
    wire tx_low = tx_above ? (tx_count < tx_trig) : tx_empty;
    wire tx_set = (tx_low & ~tx_low_q)
        | (wr_ier & wdata[UIF_IE_TX] & ~ier[UIF_IE_TX] & tx_low);

    // ======================================================================
    // time-out: start + data + parity + stop per char, times four, plus 12
    wire [3:0] char_bits = UIF_START_BITS + UIF_WL_BASE + {2'b00, line_control[1:0]}
        + {3'b000, line_control[UIF_LCR_PAR]}
        + (line_control[UIF_LCR_STOP] ? UIF_STOP_TWO : UIF_STOP_ONE);
    // a half stop bit rounds up to two, so the time-out grows by four bits
    wire [UIF_CW-1:0] to_limit = {3'b000, char_bits} * UIF_TO_CHARS
        + UIF_TO_EXTRA;
    wire to_hold = ~fifo_en | (rx_count == '0) | rx_push_evt | rd_rhr;
    wire to_fire = ~to_hold & bit_tick
        & ((to_cnt + 7'h01) == to_limit);
    wire [UIF_CW-1:0] next_to_cnt = to_hold ? '0
        : (bit_tick && to_cnt != to_limit) ? to_cnt + 7'h01 : to_cnt;

    // ======================================================================
    // read mux, unmapped and divisor slots read zero
    wire [7:0] next_rdata =
        (addr == UIF_A_DATA) ? ((div_sel) ? 8'h00 : rhr_data) :
        (addr == UIF_A_IER) ? (enh_set ? feature_control : div_sel ? 8'h00 : ier) :
        (addr == UIF_A_ISR) ? (enh_set ? enhanced_feature_control : isr_val) :
        (addr == UIF_A_LCR) ? line_control :
        (addr == UIF_A_LSR) ? line_status :
        (addr == UIF_A_MSR) ? modem_status : 8'h00;

    // ======================================================================
    // line format outputs
    assign data_bits = UIF_WL_BASE + {2'b00, line_control[1:0]};
    assign stop_long = line_control[UIF_LCR_STOP];
    assign stop_half = line_control[UIF_LCR_STOP] & (line_control[1:0] == 2'b00);
    assign parity_en = line_control[UIF_LCR_PAR];

    // ======================================================================
    // bus side registers and strobes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= 8'h00;
            tx_data <= 8'h00;
            rx_pop <= 1'b0;
            tx_push <= 1'b0;
        end else begin
            if (rd_ok) begin
                rdata <= next_rdata;
            end
            if (wr_thr) begin
                tx_data <= wdata;
            end
            rx_pop <= rd_rhr;
            tx_push <= wr_thr;
        end
    end

    // control registers; fifo fields move only with the enable bit set
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ier <= UIF_REG_RST;
            line_control <= UIF_REG_RST;
            enhanced_feature_control <= UIF_REG_RST;
            feature_control <= UIF_REG_RST;
            fifo_en <= 1'b0;
            dma_mode <= 1'b0;
            rx_idx <= 2'b00;
            tx_idx <= 2'b00;
            prog_rx <= UIF_TRIG_ONE;
            prog_tx <= UIF_TRIG_ONE;
            rx_fifo_reset <= 1'b0;
            tx_fifo_reset <= 1'b0;
        end else begin
            rx_fifo_reset <= wr_fcr & fcr_go & wdata[UIF_FCR_RXRST];
            tx_fifo_reset <= wr_fcr & fcr_go & wdata[UIF_FCR_TXRST];
            if (wr_ier) begin
                ier <= {enh_on ? wdata[7:4] : ier[7:4], wdata[3:0]};
            end
            if (wr_lcr) begin
                line_control <= wdata;
            end
            if (wr_efr) begin
                enhanced_feature_control <= wdata;
            end
            if (wr_feature_control) begin
                feature_control <= wdata;
            end
            if (wr_trg && feature_control[UIF_FEATURE_CONTROL_DIR]) begin
                prog_tx <= wdata[UIF_CW-1:0];
            end
            if (wr_trg && !feature_control[UIF_FEATURE_CONTROL_DIR]) begin
                prog_rx <= wdata[UIF_CW-1:0];
            end
            if (wr_fcr) begin
                fifo_en <= fcr_go;
            end
            if (wr_fcr && fcr_go) begin
                dma_mode <= wdata[UIF_FCR_DMA];
                rx_idx <= wdata[7:6];
                if (enh_on) begin
                    tx_idx <= wdata[5:4];
                end
            end
        end
    end

    // sticky sources; a set in the clearing cycle wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lsr_f <= 1'b0;
            to_f <= 1'b0;
            tx_f <= 1'b0;
            ms_f <= 1'b0;
            xoff_f <= 1'b0;
            spc_f <= 1'b0;
            rts_f <= 1'b0;
            cts_f <= 1'b0;
        end else begin
            lsr_f <= line_err_evt | (lsr_f & ~rd_lsr);
            to_f <= to_fire | (to_f & ~rd_rhr);
            tx_f <= tx_set | (tx_f & ~tx_shown & ~wr_thr);
            ms_f <= modem_evt | (ms_f & ~rd_msr);
            rts_f <= rts_rise_evt | (rts_f & ~rd_msr);
            cts_f <= cts_rise_evt | (cts_f & ~rd_msr);
            xoff_f <= xoff_evt | (xoff_f & ~rd_isr & ~xon_evt);
            spc_f <= special_evt
                | (spc_f & ~rd_isr & ~rx_push_evt);
        end
    end

    // transmit reload tracking and time-out counter
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_above <= 1'b0;
            // empty fifo is the idle level, so no false edge after reset
            tx_low_q <= 1'b1;
            to_cnt <= '0;
        end else begin
            tx_above <= (tx_count > tx_trig) | (tx_above & ~tx_empty);
            tx_low_q <= tx_low;
            to_cnt <= next_to_cnt;
        end
    end

    // ready pins, low when active; dma mode uses trigger and fifo room
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            receive_ready_pin_n <= 1'b1;
            transmit_ready_pin_n <= 1'b1;
        end else begin
            receive_ready_pin_n <= dma_mode ? ~(rx_lvl | to_f)
                : (rx_count == '0);
            transmit_ready_pin_n <= dma_mode
                ? (tx_count >= UIF_CW'(FIFO_DEPTH)) : ~tx_empty;
        end
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence isr_read_s;
        rd_isr ##1 1'b1;
    endsequence

    lsr_clear_a: assert property (rd_lsr && !line_err_evt |=> !lsr_f)
        else $error("line status flag survived its read");
    rx_level_a: assert property (rd_isr && ier[UIF_IE_RX] && rx_lvl
        && !pend[0] && !pend[1] |=> rdata[5:0] == UIF_ISR_CODE[2])
        else $error("receive level not reported");
    to_clear_a: assert property (rd_rhr |=> !to_f)
        else $error("time-out flag survived receive read");
    tx_clear_a: assert property (wr_thr && !tx_set |=> !tx_f)
        else $error("transmit flag survived holding write");
    msr_clear_a: assert property (rd_msr && !modem_evt && !cts_rise_evt
        |=> !ms_f && !cts_f)
        else $error("modem flags survived modem read");
    xoff_clear_a: assert property (xon_evt && !xoff_evt |=> !xoff_f)
        else $error("xoff flag survived xon");
    no_int_a: assert property (rd_isr && pend == '0
        |=> rdata[5:0] == UIF_ISR_NONE && $past(irq) == 1'b0)
        else $error("idle status code wrong");
    fifo_bits_a: assert property (isr_read_s
        |-> rdata[7:6] == {2{$past(fifo_en)}})
        else $error("fifo status bits wrong");
    fcr_ignore_a: assert property (wr_fcr && !fcr_go
        |=> $stable(dma_mode) && $stable(rx_idx))
        else $error("fifo fields moved without enable");
    rx_reset_a: assert property (wr_fcr && fcr_go && wdata[UIF_FCR_RXRST]
        |=> rx_fifo_reset ##1 !rx_fifo_reset)
        else $error("receive fifo reset not a single pulse");
    wl_a: assert property (wr_lcr |=> data_bits ==
        UIF_WL_BASE + {2'b00, $past(wdata[1:0])})
        else $error("word length not applied");
    to_fire_a: assert property (to_fire |=> to_f [*2]
        or (to_f ##1 $fell(to_f)))
        else $error("time-out not raised at limit");
endmodule

// file: rtl/uif_int_prio.sv
// Purpose: picks the highest pending interrupt source and its code
// Assumes: pending inputs are already gated by their enables
// Notes: purely combinational, read through a register by the caller
`timescale 1ns/10ps
module uif_int_prio import uif_pkg::*; (
    input wire logic [UIF_NSRC-1:0] pend,
    output logic [5:0] code,
    output logic any
);
    // ======================================================================
    // priority chain, lower index wins
    logic [UIF_NSRC-1:0] above;
    logic [UIF_NSRC-1:0] win;
    logic [UIF_NSRC-1:0][5:0] part;

    assign above[0] = 1'b0;
    genvar i;
    generate
        for (i = 1; i < UIF_NSRC; i++) begin : g_above
            assign above[i] = above[i-1] | pend[i-1];
        end
        for (i = 0; i < UIF_NSRC; i++) begin : g_win
            // only one source shows, the rest wait their turn
            assign win[i] = pend[i] & ~above[i];
            assign part[i] = win[i] ? UIF_ISR_CODE[i] : 6'h00;
        end
    endgenerate

    // codes of losing sources are zero, so an or-reduce selects
    always_comb begin
        code = any ? 6'h00 : UIF_ISR_NONE;
        for (int k = 0; k < UIF_NSRC; k++) begin
            code = code | part[k];
        end
    end
    assign any = |pend;
endmodule

// file: rtl/uif_pkg.sv
// Purpose: shared constants for the uart interrupt, fifo and line control
// Assumes: one 8-bit register port with a 3-bit address
// Notes: trigger tables are packed arrays indexed by the two-bit selects
package uif_pkg;
    // ======================================================================
    // widths and register offsets
    localparam int UIF_CW = 7;
    localparam logic [2:0] UIF_A_DATA = 3'h0;
    localparam logic [2:0] UIF_A_IER = 3'h1;
    localparam logic [2:0] UIF_A_ISR = 3'h2;
    localparam logic [2:0] UIF_A_LCR = 3'h3;
    localparam logic [2:0] UIF_A_LSR = 3'h5;
    localparam logic [2:0] UIF_A_MSR = 3'h6;
    // enhanced set, visible while line_control holds the key value
    localparam logic [2:0] UIF_A_TRG = 3'h0;
    localparam logic [2:0] UIF_A_FEATURE_CONTROL = 3'h1;
    localparam logic [2:0] UIF_A_EFR = 3'h2;
    localparam logic [7:0] UIF_LCR_KEY = 8'hbf;
    localparam logic [7:0] UIF_REG_RST = 8'h00;
    // ======================================================================
    // field positions
    localparam int UIF_FCR_EN = 0;
    localparam int UIF_FCR_RXRST = 1;
    localparam int UIF_FCR_TXRST = 2;
    localparam int UIF_FCR_DMA = 3;
    localparam int UIF_LCR_STOP = 2;
    localparam int UIF_LCR_PAR = 3;
    localparam int UIF_LCR_DIV = 7;
    localparam int UIF_EFR_ENH = 4;
    localparam int UIF_FEATURE_CONTROL_DIR = 7;
    localparam int UIF_IE_RX = 0;
    localparam int UIF_IE_TX = 1;
    localparam int UIF_IE_LS = 2;
    localparam int UIF_IE_MS = 3;
    localparam int UIF_IE_XOFF = 5;
    localparam int UIF_IE_RTS = 6;
    localparam int UIF_IE_CTS = 7;
    // ======================================================================
    // status codes, index 0 is the highest priority
    localparam int UIF_NSRC = 7;
    localparam logic [UIF_NSRC-1:0][5:0] UIF_ISR_CODE =
        {6'h20, 6'h10, 6'h00, 6'h02, 6'h04, 6'h0c, 6'h06};
    localparam logic [5:0] UIF_ISR_NONE = 6'h01;
    // ======================================================================
    // trigger tables
    typedef enum logic [1:0] {
        UIF_TAB_A = 2'b00, UIF_TAB_B = 2'b01, UIF_TAB_C = 2'b10,
        UIF_TAB_D = 2'b11
    } uif_tab_e;
    localparam logic [UIF_CW-1:0] UIF_TRIG_ONE = 7'h01;
    localparam logic [3:0][UIF_CW-1:0] UIF_RX_A = {7'h0e, 7'h08, 7'h04, 7'h01};
    localparam logic [3:0][UIF_CW-1:0] UIF_RX_B = {7'h1c, 7'h18, 7'h10, 7'h08};
    localparam logic [3:0][UIF_CW-1:0] UIF_TX_B = {7'h1e, 7'h18, 7'h08, 7'h10};
    localparam logic [3:0][UIF_CW-1:0] UIF_RX_C = {7'h3c, 7'h38, 7'h10, 7'h08};
    localparam logic [3:0][UIF_CW-1:0] UIF_TX_C = {7'h38, 7'h20, 7'h10, 7'h08};
    // ======================================================================
    // character format and receive time-out, in bit times
    localparam logic [3:0] UIF_START_BITS = 4'h1;
    localparam logic [3:0] UIF_WL_BASE = 4'h5;
    localparam logic [3:0] UIF_STOP_ONE = 4'h1;
    localparam logic [3:0] UIF_STOP_TWO = 4'h2;
    localparam logic [UIF_CW-1:0] UIF_TO_CHARS = 7'h04;
    localparam logic [UIF_CW-1:0] UIF_TO_EXTRA = 7'h0c;
endpackage

// file: rtl/uif_trig_sel.sv
// Purpose: trigger level lookup for both fifo directions
// Assumes: one table select shared by receive and transmit
// Notes: without fifos both levels collapse to a single character
`timescale 1ns/10ps
module uif_trig_sel import uif_pkg::*; (
    input wire logic fifo_en,
    input wire logic [1:0] table_sel,
    input wire logic [1:0] rx_idx,
    input wire logic [1:0] tx_idx,
    input wire logic [UIF_CW-1:0] prog_rx,
    input wire logic [UIF_CW-1:0] prog_tx,
    output logic [UIF_CW-1:0] rx_trig,
    output logic [UIF_CW-1:0] tx_trig
);
    // ======================================================================
    // table lookup, used once per direction
    function automatic logic [UIF_CW-1:0] pick(input logic dir_tx,
            input logic [1:0] tab, input logic [1:0] idx,
            input logic [UIF_CW-1:0] prog);
        case (tab)
            UIF_TAB_A: pick = dir_tx ? UIF_TRIG_ONE : UIF_RX_A[idx];
            UIF_TAB_B: pick = dir_tx ? UIF_TX_B[idx] : UIF_RX_B[idx];
            UIF_TAB_C: pick = dir_tx ? UIF_TX_C[idx] : UIF_RX_C[idx];
            default: pick = prog;
        endcase
    endfunction

    // one select for both sides, so the last written table wins
    assign rx_trig = fifo_en ? pick(1'b0, table_sel, rx_idx, prog_rx)
        : UIF_TRIG_ONE;
    assign tx_trig = fifo_en ? pick(1'b1, table_sel, tx_idx, prog_tx)
        : UIF_TRIG_ONE;
endmodule

// file: test/tb.sv
// Purpose: self-checking bench for the channel control registers
// Assumes: engine side comes from uif_engine_model
// Notes: read data is checked against a queue of expected values
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
$display("BAD %0t got %h want %h", $time, (g), (e)); end end
module tb import uif_pkg::*; ;
    logic ref_clk = 0, rst = 1, cs = 0, rd_strobe = 0, wr_strobe = 0;
    logic [2:0] addr = '0;
    logic [7:0] wdata = '0, line_status = '0, modem_status = '0;
    logic [7:0] rdata, tx_data, rhr_data, rnd, exp_v;
    logic [6:0] ev = '0;
    logic char_in = 0, tick_on = 0, bit_tick, rx_push_evt, irq;
    logic [UIF_CW-1:0] rx_count, tx_count;
    logic rx_pop, tx_push, rx_fifo_reset, tx_fifo_reset, fifo_en, dma_mode;
    logic stop_long, stop_half, parity_en;
    logic receive_ready_pin_n, transmit_ready_pin_n;
    logic [3:0] data_bits;
    logic [7:0] expq[$];
    int err_total = 0, compares = 0;
    // ==================================================================
    // clock and instances
    always #4 ref_clk = ~ref_clk;
    uif_ctrl #(.FIFO_DEPTH(64)) uif_ctrl_i (.ref_clk, .rst, .cs, .addr,
        .rd_strobe, .wr_strobe, .wdata, .rdata, .rhr_data, .line_status,
        .modem_status, .rx_count, .tx_count, .bit_tick, .rx_push_evt,
        .line_err_evt(ev[0]), .modem_evt(ev[1]), .xoff_evt(ev[2]),
        .xon_evt(ev[3]), .special_evt(ev[4]), .rts_rise_evt(ev[5]),
        .cts_rise_evt(ev[6]), .rx_pop, .tx_push, .tx_data, .rx_fifo_reset,
        .tx_fifo_reset, .fifo_en, .dma_mode, .data_bits, .stop_long,
        .stop_half, .parity_en, .irq, .receive_ready_pin_n,
        .transmit_ready_pin_n);
    uif_engine_model uif_engine_model_i (.ref_clk, .rst, .rx_pop, .tx_push,
        .rx_fifo_reset, .tx_fifo_reset, .char_in, .tick_on, .rx_count,
        .tx_count, .rx_push_evt, .bit_tick, .rhr_data);
    // ==================================================================
    // one bus access; strobes last one cycle and an idle cycle follows before the next access
    task automatic acc(input logic w, input logic [2:0] a,
            input logic [7:0] d);
        @(negedge ref_clk);
        cs = 1;
        wr_strobe = w;
        rd_strobe = !w;
        addr = a;
        wdata = d;
        if (!w)
            expq.push_back(d);
        @(negedge ref_clk);
        cs = 0;
        wr_strobe = 0;
        rd_strobe = 0;
    endtask
    task automatic fire(input logic [6:0] m);
        @(negedge ref_clk);
        ev = m;
        @(negedge ref_clk);
        ev = '0;
    endtask
    task automatic push(input int n);
        repeat (n) begin
            @(negedge ref_clk);
            char_in = 1;
            @(negedge ref_clk);
            char_in = 0;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // read data is registered on the taken edge, checked at the next falling edge
    always begin
        @(posedge ref_clk);
        if (cs && rd_strobe) begin
            @(negedge ref_clk);
            exp_v = expq.pop_front();
            `CHK(rdata, exp_v)
        end
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
    // ==================================================================
    // main sequence
    initial begin
        rnd = $urandom(57);
        line_status = $urandom;
        modem_status = $urandom;
        repeat (5) @(negedge ref_clk);
        rst = 0;
        `CHK(data_bits, 4'h5)
        `CHK(fifo_en, 1'b0)
        acc(0, UIF_A_ISR, 8'h01);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            rnd = {1'b0, 3'($urandom), i[3:0]};
            acc(1, UIF_A_LCR, rnd);
            `CHK(data_bits, 4'h5 + i[1:0])
            `CHK(stop_long, i[2])
            `CHK(stop_half, i[2] && i[1:0] == 0)
            `CHK(parity_en, i[3])
            acc(0, UIF_A_LCR, rnd);
        end
        acc(1, UIF_A_LCR, 8'h00);
        $display("test format done");
        // enable bit left low on purpose first
        acc(1, UIF_A_ISR, 8'h08);
        `CHK(dma_mode, 1'b0)
        acc(1, UIF_A_ISR, 8'h09);
        `CHK({fifo_en, dma_mode}, 2'b11)
        acc(1, UIF_A_ISR, 8'h07);
        `CHK({rx_fifo_reset, tx_fifo_reset, dma_mode}, 3'b110)
        acc(0, UIF_A_ISR, 8'hc1);
        `CHK({rx_fifo_reset, tx_fifo_reset}, 2'b00)
        $display("test fifo control done");
        acc(1, UIF_A_IER, 8'h0c);
        fire(7'h03);
        acc(0, UIF_A_ISR, 8'hc6);
        acc(1, UIF_A_IER, 8'h08);
        acc(0, UIF_A_ISR, 8'hc0);
        acc(1, UIF_A_IER, 8'h0c);
        acc(0, UIF_A_LSR, line_status);
        acc(0, UIF_A_ISR, 8'hc0);
        `CHK(irq, 1'b1)
        acc(0, UIF_A_MSR, modem_status);
        acc(0, UIF_A_ISR, 8'hc1);
        acc(1, UIF_A_IER, 8'h02);
        rnd = $urandom;
        acc(1, UIF_A_DATA, rnd);
        `CHK({tx_push, tx_data}, {1'b1, rnd})
        repeat (4) @(negedge ref_clk);
        acc(0, UIF_A_ISR, 8'hc2);
        acc(0, UIF_A_ISR, 8'hc1);
        $display("test sources done");
        // table a, receive index 3 gives a trigger of 14
        acc(1, UIF_A_IER, 8'h01);
        acc(1, UIF_A_ISR, 8'hc1);
        push(13);
        acc(0, UIF_A_ISR, 8'hc1);
        `CHK(receive_ready_pin_n, 1'b0)
        // dma mode: below trigger the receive pin stays high
        acc(1, UIF_A_ISR, 8'hc9);
        @(negedge ref_clk);
        `CHK(receive_ready_pin_n, 1'b1)
        push(1);
        acc(0, UIF_A_ISR, 8'hc4);
        `CHK(receive_ready_pin_n, 1'b0)
        acc(0, UIF_A_DATA, 8'h0e);
        acc(0, UIF_A_ISR, 8'hc1);
        // 5 data bits, 1 stop: time-out is 4*7+12 = 40 bit times
        tick_on = 1;
        repeat (34) @(posedge bit_tick);
        acc(0, UIF_A_ISR, 8'hc1);
        repeat (8) @(posedge bit_tick);
        acc(0, UIF_A_ISR, 8'hcc);
        `CHK({receive_ready_pin_n, transmit_ready_pin_n}, 2'b00)
        tick_on = 0;
        acc(0, UIF_A_DATA, 8'h0d);
        acc(0, UIF_A_ISR, 8'hc1);
        $display("test receive done");
        // enhanced set: xoff and special sources, then shared table b
        acc(1, UIF_A_LCR, UIF_LCR_KEY);
        acc(1, UIF_A_EFR, 8'h10);
        acc(1, UIF_A_FEATURE_CONTROL, 8'h10);
        acc(1, UIF_A_LCR, 8'h00);
        acc(1, UIF_A_IER, 8'h21);
        fire(7'h04);
        acc(0, UIF_A_ISR, 8'hd0);
        acc(0, UIF_A_ISR, 8'hc1);
        fire(7'h04);
        fire(7'h08);
        acc(0, UIF_A_ISR, 8'hc1);
        fire(7'h10);
        push(1);
        acc(0, UIF_A_ISR, 8'hc1);
        // receive index 1 of table b is 16; count is 13 here
        acc(1, UIF_A_ISR, 8'h41);
        push(2);
        acc(0, UIF_A_ISR, 8'hc1);
        push(1);
        acc(0, UIF_A_ISR, 8'hc4);
        $display("test enhanced done");
        repeat (2) @(negedge ref_clk);
        tally_and_finish();
    end
endmodule

// file: test/uif_engine_model.sv
// Purpose: engine side of one channel: fifo levels, pushes, bit ticks
// Assumes: controller pulses are one ref_clk cycle wide
// Notes: transmit fifo drains one character a cycle, no shifter modelled
`timescale 1ns/10ps
module uif_engine_model import uif_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic rx_pop,
    input wire logic tx_push,
    input wire logic rx_fifo_reset,
    input wire logic tx_fifo_reset,
    input wire logic char_in,
    input wire logic tick_on,
    output logic [UIF_CW-1:0] rx_count,
    output logic [UIF_CW-1:0] tx_count,
    output logic rx_push_evt,
    output logic bit_tick,
    output logic [7:0] rhr_data
);
    // ==================================================================
    // head of fifo shows its own level, so reads are predictable
    assign rhr_data = {1'b0, rx_count};
    // levels follow pushes, pops and fifo resets
    always_ff @(posedge ref_clk) begin
        rx_push_evt <= char_in && !rst;
        bit_tick <= tick_on && !bit_tick && !rst;
        if (rst || rx_fifo_reset)
            rx_count <= '0;
        else
            rx_count <= rx_count + UIF_CW'(char_in) - UIF_CW'(rx_pop);
        if (rst || tx_fifo_reset)
            tx_count <= '0;
        else if (tx_push)
            tx_count <= tx_count + 1'b1;
        else if (tx_count != 0)
            tx_count <= tx_count - 1'b1;
    end
endmodule
